// ==== rtl/cpm_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the pin function mux.
// Included by the package and the top module; definitions only.
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH

`define CPM_NUM_PINS        10
`define CPM_SEL_W           4
`define CPM_CLK_MHZ         200
// Pin function selector register i sits at CPM_SEL_BASE + 4*i
`define CPM_SEL_BASE        12'h000
`define CPM_CTRL_ADDR       12'h040
`define CPM_STAT_ADDR       12'h044
`define CPM_LOAD_ADDR       12'h048
// Control fields
`define CPM_CTRL_PRESENT    0
`define CPM_CTRL_PD_SUSP    1
`define CPM_CTRL_RWAKE      2
`define CPM_CTRL_RESET      32'h0000_0000
// Status fields
`define CPM_STAT_SUSPEND    0
`define CPM_STAT_CONFIGURED 1
`define CPM_STAT_LOADED     2
`define CPM_STAT_RESUME     3
// Activity LED pulse stretch: 50 ms held low after last activity
`define CPM_LED_MS          50
`define CPM_LED_CYCLES      (`CPM_LED_MS * 1000 * `CPM_CLK_MHZ)

`endif

// ==== rtl/cpm_pkg.sv ====
// Types for the configurable pin function mux.
// Constants come from cpm_regs.svh.
`include "cpm_regs.svh"

package cpm_pkg;

  typedef enum logic [3:0] {
    CPM_FN_INPUT_PU  = 4'h0,
    CPM_FN_RS485_DRIVER_ENABLE     = 4'h1,
    CPM_FN_POWER_ENABLE_N     = 4'h2,
    CPM_FN_TX_ACTIVITY_LED_N     = 4'h3,
    CPM_FN_RX_ACTIVITY_LED_N     = 4'h4,
    CPM_FN_ANYLED    = 4'h5,
    CPM_FN_SLEEP     = 4'h6,
    CPM_FN_CLK_HALF  = 4'h7,
    CPM_FN_CLK_QUART = 4'h8,
    CPM_FN_CLK_EIGHT = 4'h9,
    CPM_FN_DRIVE1    = 4'hA,
    CPM_FN_DRIVE0    = 4'hB,
    CPM_FN_BITBANG   = 4'hC
  } cpm_fn_t;

  // Serial port side inputs from the UART engine
  typedef struct packed {
    logic txd;
    logic rts_n;
    logic dtr_n;
    logic tx_busy;
    logic tx_lead;
    logic rx_busy;
  } cpm_uart_out_t;

  // Modem pins as seen at the port
  typedef struct packed {
    logic rxd;
    logic cts_n;
    logic dsr_n;
    logic carrier_detect_n;
    logic ring_indicator_n;
  } cpm_uart_in_t;

endpackage

// ==== rtl/cpm_pin_mux.sv ====
// Configurable pin group function mux with default serial port pin assignment.
// Assumes a UART engine supplies frame status, a USB core supplies suspend and configured state,
// and pad cells resolve output, output enable and pull controls.
// Summary of operation
// [R1] Driver enable asserts one bit before start bit, holds until stop bit ends.
// [R2] Power enable pin low once USB configured, high during suspend.
// [R3] Transmit LED pin pulses low while transmitting.
// [R4] Receive LED pin pulses low while receiving.
// [R5] Combined LED pin pulses low when transmitting or receiving.
// [R6] Suspend indicator pin low during suspend, high otherwise.
// [R7] Clock outputs give 30, 15, 7.5 MHz; stopped in suspend. Here pclk/4, pclk/8, pclk/8: 50, 25, 25 MHz.
// [R8] Without configuration memory every pin is a pulled-up input.
// [R9] Pin functions come from configuration memory, used only when present.
// [R10] Optional: input pins switch to weak pull-down during suspend.
// [R11] Configurer enables suspend pull-down when power enable switches power.
// [R12] Interface pins default to asynchronous serial port operation.
// [R13] Serial mode: data, request, terminal-ready out; other modem lines in.
// [R14] Ring indicator low while suspended with wakeup enabled signals resume.
// [R15] Each pin holds a selector loaded from configuration at start-up.
`timescale 1ns/1ps
`include "cpm_regs.svh"

module cpm_pin_mux
  import cpm_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       usb_suspend,
  input  wire logic                       usb_configured,
  input  wire cpm_uart_out_t              uart_out,
  output cpm_uart_in_t                    uart_in,
  input  wire logic [7:0]                 serial_pin_in,
  output logic      [7:0]                 serial_pin_out,
  output logic      [7:0]                 serial_pin_oe,
  input  wire logic [`CPM_NUM_PINS-1:0]   config_pin_group_in,
  output logic      [`CPM_NUM_PINS-1:0]   config_pin_group_out,
  output logic      [`CPM_NUM_PINS-1:0]   config_pin_group_oe,
  output logic      [`CPM_NUM_PINS-1:0]   config_pin_group_pu,
  output logic      [`CPM_NUM_PINS-1:0]   config_pin_group_pd,
  output logic      [`CPM_NUM_PINS-1:0]   bitbang_in,
  input  wire logic [`CPM_NUM_PINS-1:0]   bitbang_out,
  input  wire logic [`CPM_NUM_PINS-1:0]   bitbang_oe,
  output logic                            resume_request
);

  localparam int LED_W = $clog2(`CPM_LED_CYCLES + 1);
  localparam logic [LED_W-1:0] LED_LOAD = LED_W'(`CPM_LED_CYCLES);

  // Stored configuration
  cpm_fn_t           sel [`CPM_NUM_PINS];
  cpm_fn_t           cfg [`CPM_NUM_PINS];
  logic [31:0]       ctrl;
  logic              loaded;
  logic [2:0]        clk_div;
  logic [LED_W-1:0]  tx_led_cnt;
  logic [LED_W-1:0]  rx_led_cnt;

  // Bus decode
  wire        acc       = psel & penable;
  wire        wr        = acc & pwrite;
  wire        sel_hit   = (paddr < (`CPM_SEL_BASE + 12'(4 * `CPM_NUM_PINS))) && (paddr[1:0] == 2'b00);
  wire [3:0]  sel_idx   = paddr[5:2];
  wire        ctrl_hit  = (paddr == `CPM_CTRL_ADDR);
  wire        stat_hit  = (paddr == `CPM_STAT_ADDR);
  wire        load_hit  = (paddr == `CPM_LOAD_ADDR);
  wire        any_hit   = sel_hit | ctrl_hit | stat_hit | load_hit;
  wire        present   = ctrl[`CPM_CTRL_PRESENT];
  wire        pd_susp   = ctrl[`CPM_CTRL_PD_SUSP];
  wire        rwake     = ctrl[`CPM_CTRL_RWAKE];
  // [R15] start-up load strobe
  wire        load_now  = wr & load_hit;

  wire [3:0]  stat_bits = {resume_request, loaded, usb_configured, usb_suspend};
  wire [31:0] stat_word = {28'h000_0000, stat_bits};
  wire [31:0] sel_word  = {28'h000_0000, cfg[sel_idx]};
  wire [31:0] next_rdata = sel_hit  ? sel_word :
                           ctrl_hit ? ctrl :
                           stat_hit ? stat_word : 32'h0000_0000;

  // Zero wait states: the setup cycle launches pready for the first access cycle
  wire        setup_now   = psel & ~penable;
  wire        next_slverr = setup_now & ~any_hit;
  wire [31:0] next_prdata = (setup_now & ~pwrite) ? next_rdata : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_now;
      pslverr <= next_slverr;
      prdata  <= next_prdata;
    end
  end

  wire bus_done = acc & pready;
  wire ctrl_wr  = bus_done & pwrite & ctrl_hit;
  wire load_wr  = bus_done & load_now;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= `CPM_CTRL_RESET;
      loaded <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl <= {29'h0000_0000, pwdata[2:0]};
      end
      if (load_wr) begin
        loaded <= 1'b1;
      end
    end
  end

  // Clock divider and activity stretch
  wire clk_run   = ~usb_suspend;
  wire tx_act    = uart_out.tx_busy;
  wire rx_act    = uart_out.rx_busy;
  wire tx_led_on = (tx_led_cnt != '0);
  wire rx_led_on = (rx_led_cnt != '0);

  // [R7] clocks halt in suspend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_div <= 3'h0;
    end else begin
      clk_div <= clk_run ? clk_div + 3'h1 : 3'h0;
    end
  end

  // Stretch keeps a short burst visible on an LED
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_led_cnt <= '0;
    end else begin
      tx_led_cnt <= tx_act ? LED_LOAD : (tx_led_on ? tx_led_cnt - 1'b1 : tx_led_cnt);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_led_cnt <= '0;
    end else begin
      rx_led_cnt <= rx_act ? LED_LOAD : (rx_led_on ? rx_led_cnt - 1'b1 : rx_led_cnt);
    end
  end

  // [R1] driver enable spans lead bit to stop bit
  wire rs485_driver_enable_lvl  = uart_out.tx_lead | uart_out.tx_busy;
  // [R2] power enable level
  wire power_enable_n_lvl  = usb_suspend | ~usb_configured;
  // [R6] suspend indicator level
  wire sleep_lvl  = ~usb_suspend;
  // [R3] [R4] [R5] active-low LED levels
  wire tx_activity_led_n_lvl  = ~tx_led_on;
  wire rx_activity_led_n_lvl  = ~rx_led_on;
  wire anyled_lvl = ~(tx_led_on | rx_led_on);
  // [R7] divided clock levels, low while stopped
  wire half_lvl   = ~clk_div[1] & clk_run;
  wire quart_lvl  = ~clk_div[2] & clk_run;
  wire eighth_lvl = clk_div[2] & clk_div[1] & clk_run;

  // One writer per pad vector; the pin loop only computes next values
  logic [`CPM_NUM_PINS-1:0] next_pin_out;
  logic [`CPM_NUM_PINS-1:0] next_pin_oe;
  logic [`CPM_NUM_PINS-1:0] next_pin_pu;
  logic [`CPM_NUM_PINS-1:0] next_pin_pd;
  logic [`CPM_NUM_PINS-1:0] cfg_wr;

  genvar gi;
  generate
    for (gi = 0; gi < `CPM_NUM_PINS; gi++) begin : g_pin
      cpm_fn_t fn;
      logic    next_out;
      logic    next_oe;
      // [R9] stored function used only when memory present
      assign fn = present ? sel[gi] : CPM_FN_INPUT_PU;
      // [R15] staged selector write decode
      assign cfg_wr[gi] = bus_done & pwrite & sel_hit & (sel_idx == 4'(gi));

      always_comb begin
        next_out = 1'b1;
        next_oe  = 1'b1;
        unique case (fn)
          CPM_FN_RS485_DRIVER_ENABLE:     next_out = rs485_driver_enable_lvl;
          CPM_FN_POWER_ENABLE_N:     next_out = power_enable_n_lvl;
          // [R3] transmit led
          CPM_FN_TX_ACTIVITY_LED_N:     next_out = tx_activity_led_n_lvl;
          // [R4] receive led
          CPM_FN_RX_ACTIVITY_LED_N:     next_out = rx_activity_led_n_lvl;
          // [R5] combined led
          CPM_FN_ANYLED:    next_out = anyled_lvl;
          CPM_FN_SLEEP:     next_out = sleep_lvl;
          // [R7] divided clock outputs
          CPM_FN_CLK_HALF:  next_out = half_lvl;
          CPM_FN_CLK_QUART: next_out = quart_lvl;
          CPM_FN_CLK_EIGHT: next_out = eighth_lvl;
          CPM_FN_DRIVE1:    next_out = 1'b1;
          CPM_FN_DRIVE0:    next_out = 1'b0;
          CPM_FN_BITBANG: begin
            next_out = bitbang_out[gi];
            next_oe  = bitbang_oe[gi];
          end
          // [R8] default pulled-up input
          default: begin
            next_out = 1'b0;
            next_oe  = 1'b0;
          end
        endcase
      end

      assign next_pin_out[gi] = next_out;
      assign next_pin_oe[gi]  = next_oe;
      // [R10] suspend pull-down option
      assign next_pin_pd[gi]  = ~next_oe & pd_susp & usb_suspend;
      assign next_pin_pu[gi]  = ~next_oe & ~(pd_susp & usb_suspend);
    end
  endgenerate

  // Staged and active selectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `CPM_NUM_PINS; i++) begin
        sel[i] <= CPM_FN_INPUT_PU;
        cfg[i] <= CPM_FN_INPUT_PU;
      end
    end else begin
      for (int i = 0; i < `CPM_NUM_PINS; i++) begin
        if (cfg_wr[i]) begin
          cfg[i] <= cpm_fn_t'(pwdata[3:0]);
        end
        // [R15] selector loaded at start-up
        if (load_wr) begin
          sel[i] <= cfg[i];
        end
      end
    end
  end

  // Pad controls; reset leaves every pin a pulled-up input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_pin_group_out <= '0;
      config_pin_group_oe  <= '0;
      config_pin_group_pu  <= '1;
      config_pin_group_pd  <= '0;
      bitbang_in           <= '0;
    end else begin
      config_pin_group_out <= next_pin_out;
      config_pin_group_oe  <= next_pin_oe;
      config_pin_group_pu  <= next_pin_pu;
      config_pin_group_pd  <= next_pin_pd;
      bitbang_in           <= config_pin_group_in;
    end
  end

  // [R12] [R13] default serial port pin assignment
  wire [7:0] ser_oe = 8'h15;
  wire [7:0] ser_o;
  assign ser_o[0]   = uart_out.txd;
  assign ser_o[1]   = 1'b0;
  assign ser_o[2]   = uart_out.rts_n;
  assign ser_o[3]   = 1'b0;
  assign ser_o[4]   = uart_out.dtr_n;
  assign ser_o[7:5] = 3'h0;

  // Modem inputs in port order
  cpm_uart_in_t next_uart_in;
  assign next_uart_in = '{rxd:              serial_pin_in[1],
                          cts_n:            serial_pin_in[3],
                          dsr_n:            serial_pin_in[5],
                          carrier_detect_n: serial_pin_in[6],
                          ring_indicator_n: serial_pin_in[7]};
  // [R14] ring indicator wakes the host
  wire next_resume = rwake & usb_suspend & ~serial_pin_in[7];

  // Serial pins and modem inputs, registered like the pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_pin_out <= 8'h15;
      serial_pin_oe  <= 8'h00;
      uart_in        <= '1;
      resume_request <= 1'b0;
    end else begin
      serial_pin_out <= ser_o;
      serial_pin_oe  <= ser_oe;
      uart_in        <= next_uart_in;
      resume_request <= next_resume;
    end
  end

endmodule

// ==== tb/cpm_pin_mux_checker.sv ====
// Port-level assertions for the pin function mux.
// Assumes it is bound into cpm_pin_mux; sees only its ports.
`timescale 1ns/1ps
`include "cpm_regs.svh"
module cpm_pin_mux_checker
  import cpm_pkg::*;
(
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     usb_suspend,
  input wire cpm_uart_in_t             uart_in,
  input wire logic [7:0]               serial_pin_in,
  input wire logic [7:0]               serial_pin_oe,
  input wire logic [`CPM_NUM_PINS-1:0] config_pin_group_pu,
  input wire logic [`CPM_NUM_PINS-1:0] config_pin_group_pd,
  input wire logic                     resume_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("pready missing in access cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_serial_dirs: assert property ($past(presetn) |-> serial_pin_oe == 8'h15)
    else $error("serial pin directions wrong");
  a_modem_copy: assert property ($past(presetn) |-> uart_in ==
    $past({serial_pin_in[1], serial_pin_in[3], serial_pin_in[5], serial_pin_in[6], serial_pin_in[7]}))
    else $error("modem inputs not copied");
  a_resume_cause: assert property (!$past(usb_suspend) || $past(serial_pin_in[7]) |-> !resume_request)
    else $error("resume without cause");
  a_pull_exclusive: assert property ((config_pin_group_pu & config_pin_group_pd) == '0)
    else $error("pull-up and pull-down together");
  a_pd_in_suspend: assert property (|config_pin_group_pd |-> $past(usb_suspend))
    else $error("pull-down outside suspend");
endmodule
bind cpm_pin_mux cpm_pin_mux_checker chk_i (.*);

// ==== tb/cpm_far_side.sv ====
// Far side of the configurable pins: LEDs, converters, switches.
// Resolves each pad from drive and pulls; a floating pad shows no stale level.
`timescale 1ns/1ps
module cpm_far_side (
  input  wire logic       pclk,
  input  wire logic [9:0] pad_out,
  input  wire logic [9:0] pad_oe,
  input  wire logic [9:0] pad_pu,
  input  wire logic [9:0] pad_pd,
  output logic      [9:0] pad_in
);
  logic [9:0] last;
  always @* begin
    for (int i = 0; i < 10; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : pad_pu[i] ? 1'b1 : pad_pd[i] ? 1'b0 : ~last[i];
    end
  end
  always @(posedge pclk) last <= pad_in;
endmodule

// ==== tb/cpm_pin_mux_tb.sv ====
// Self-checking bench for the pin function mux.
// Assumes the checker binds itself and cpm_far_side resolves the pads.
`timescale 1ns/1ps
module cpm_pin_mux_tb
  import cpm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, usb_suspend, usb_configured, resume_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  cpm_uart_out_t uart_out;
  cpm_uart_in_t  uart_in;
  logic [7:0] serial_pin_in, serial_pin_out, serial_pin_oe;
  logic [9:0] config_pin_group_in, config_pin_group_out, config_pin_group_oe, config_pin_group_pu;
  logic [9:0] config_pin_group_pd, bitbang_in, bitbang_out, bitbang_oe;
  int n_mismatch, checks, cyc, r, h;
  logic p;
  cpm_fn_t fn [10] = '{CPM_FN_RS485_DRIVER_ENABLE, CPM_FN_POWER_ENABLE_N, CPM_FN_SLEEP, CPM_FN_DRIVE1, CPM_FN_DRIVE0,
                       CPM_FN_TX_ACTIVITY_LED_N, CPM_FN_BITBANG, CPM_FN_CLK_HALF, CPM_FN_INPUT_PU, CPM_FN_RX_ACTIVITY_LED_N};
  cpm_pin_mux uut (.*);
  cpm_far_side far (.pclk(pclk), .pad_out(config_pin_group_out), .pad_oe(config_pin_group_oe),
                    .pad_pu(config_pin_group_pu), .pad_pd(config_pin_group_pd), .pad_in(config_pin_group_in));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] er, input logic ee);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) chk(prdata, er);
    chk(pslverr, ee);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task edges(input int b, output int rises, output int highs);
    @(posedge pclk);
    p = config_pin_group_out[b];
    rises = 0;
    highs = 0;
    repeat (16) begin
      @(posedge pclk);
      if (config_pin_group_out[b]) highs++;
      if (config_pin_group_out[b] && !p) rises++;
      p = config_pin_group_out[b];
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task s_defaults;
    apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h04C, 32'h0, 32'h0, 1'b1);
    chk(serial_pin_oe, 8'h15);
    chk(config_pin_group_pu, 10'h3FF);
    chk(config_pin_group_oe, 10'h000);
  endtask
  task s_serial;
    uart_out <= '{txd:1'b0, rts_n:1'b0, dtr_n:1'b1, default:1'b0};
    serial_pin_in <= 8'h42;
    wt(3);
    chk(serial_pin_out, 8'h10);
    chk(uart_in, 5'b10010);
    serial_pin_in <= 8'hFF;
  endtask
  task s_functions;
    for (int i = 0; i < 10; i++) apb(1'b1, 12'(4 * i), {28'h0, fn[i]}, 32'h0, 1'b0);
    apb(1'b1, 12'h048, 32'h0, 32'h0, 1'b0);
    wt(3);
    chk(config_pin_group_pu, 10'h3FF);
    apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
    apb(1'b1, 12'h040, 32'h7, 32'h0, 1'b0);
    apb(1'b1, 12'h048, 32'h0, 32'h0, 1'b0);
    usb_configured <= 1'b1; bitbang_out <= 10'h040; bitbang_oe <= 10'h040; uart_out.tx_lead <= 1'b1;
    wt(3);
    chk(config_pin_group_oe[6:0], 7'h7F);
    chk(config_pin_group_out[6:0], 7'b1101101);
    chk(bitbang_in[4:3], 2'b01);
    uart_out.tx_lead <= 1'b0; uart_out.tx_busy <= 1'b1; uart_out.rx_busy <= 1'b1;
    wt(3);
    chk({config_pin_group_out[5], config_pin_group_out[0]}, 2'b01);
    chk(config_pin_group_out[9], 1'b0);
    uart_out.tx_busy <= 1'b0;
    wt(3);
    chk(config_pin_group_out[0], 1'b0);
    edges(7, r, h);
    chk(r, 4);
    chk(h, 8);
  endtask
  task s_more;
    apb(1'b1, 12'h00C, {28'h0, CPM_FN_ANYLED}, 32'h0, 1'b0);
    apb(1'b1, 12'h010, {28'h0, CPM_FN_CLK_QUART}, 32'h0, 1'b0);
    apb(1'b1, 12'h020, {28'h0, CPM_FN_CLK_EIGHT}, 32'h0, 1'b0);
    apb(1'b1, 12'h048, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h044, 32'h0, 32'h6, 1'b0);
    chk(config_pin_group_out[3], 1'b0);
    edges(4, r, h);
    chk(r, 2);
    chk(h, 8);
    edges(8, r, h);
    chk(r, 2);
    chk(h, 4);
    usb_suspend <= 1'b1;
    edges(8, r, h);
    chk(h, 0);
    usb_suspend <= 1'b0;
  endtask
  task s_suspend;
    usb_suspend <= 1'b1; serial_pin_in <= 8'h7F;
    wt(3);
    chk({config_pin_group_out[7], config_pin_group_out[2:1]}, 3'b001);
    chk({config_pin_group_pd[8], config_pin_group_pu[8]}, 2'b10);
    chk(resume_request, 1'b1);
    usb_suspend <= 1'b0;
    wt(3);
    chk(resume_request, 1'b0);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; usb_suspend = 0;
    usb_configured = 0; uart_out = '0; serial_pin_in = 8'hFF; bitbang_out = 0; bitbang_oe = 0;
    wt(5);
    presetn <= 1'b1;
    s_defaults;
    s_serial;
    s_functions;
    s_suspend;
    s_more;
    tally_and_finish;
  end
endmodule
